/* File: hw/fine_gain_defines.vh */
// Constants for the fine gain temperature compensation block
`ifndef FINE_GAIN_DEFINES_VH
`define FINE_GAIN_DEFINES_VH

// Calibration memory geometry
`define CAL_DEPTH          64
`define CAL_ADDR_W         6
`define CAL_WORD_W         5
`define CAL_DATA_W         4
`define CAL_PARITY_BIT     4

// Base locations of multi-nibble values, low nibble first, and the config location
`define LOC_ROOM_TEMP      6'h00
`define LOC_GAIN_QUAD      6'h04
`define LOC_CONFIG         6'h07
`define LOC_GAIN_LIN       6'h08
`define LOC_GAIN_CONST     6'h0c

// Field positions in the configuration location
`define CFG_INPUT_SWAP     0
`define CFG_STAGE1_GAIN    1
`define CFG_STAGE2_GAIN    2
`define CFG_STAGE3_GAIN    3

// Coefficient and code widths
`define COEFF_W            12
`define TEMP_W             10
`define CODE_W             10

// Fixed-point shifts back to the 2^-11 result scale
`define LIN_SHIFT          10
`define QUAD_SHIFT         21

// Chopper half period in clock cycles
`define CHOP_HALF_CYCLES   8

`endif

/* File: hw/gain_poly_alu.v */
// Multi-cycle ALU for the second-order fine gain polynomial
`timescale 1ns/100ps
`include "fine_gain_defines.vh"

module gain_poly_alu (
    input  wire        clock_in,     // System clock
    input  wire        sys_rst_in,   // Synchronous reset
    input  wire        start_in,     // Start pulse
    input  wire [9:0]  temp_in,      // Current temperature code
    input  wire [11:0] t_ref_in,     // Room temperature reference
    input  wire [11:0] const_coeff_in, // Constant coefficient
    input  wire [11:0] lin_coeff_in,   // Linear coefficient
    input  wire [11:0] quad_coeff_in,  // Quadratic coefficient
    output wire        busy_out,     // Calculation running
    output reg         done_out,     // Result valid pulse
    output reg  [9:0]  result_out,   // Truncated 10-bit fraction
    output reg         overflow_out  // Result outside 0 to 1
);

    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_DIFF = 3'h1;
    localparam [2:0] S_MUL  = 3'h2;
    localparam [2:0] S_QUAD = 3'h3;
    localparam [2:0] S_SUM  = 3'h4;

    reg        [2:0]  state;   // Sequencer state
    reg signed [11:0] dt;      // Temperature difference, 2^-11 scale
    reg signed [23:0] dt_sq;   // Difference squared, 2^-22 scale
    reg signed [23:0] lin;     // Linear term, 2^-21 scale
    reg signed [35:0] quad;    // Quadratic term, 2^-32 scale

    // Sum of all terms at 2^-11 scale, 12-bit precision kept
    wire signed [35:0] lin_x = {{12{lin[23]}}, lin};
    wire signed [35:0] sum   = (lin_x >>> `LIN_SHIFT) + (quad >>> `QUAD_SHIFT)
                             + $signed({25'h0, const_coeff_in[9:0], 1'b0});
    // Below zero or at/above one is out of range
    wire sum_out_of_range = sum[35] | (|sum[34:11]);

    assign busy_out = (state != S_IDLE);

    // Polynomial sequencer
    always @(posedge clock_in) begin
        if (sys_rst_in) begin
            state        <= S_IDLE;
            dt           <= 12'sh000;
            dt_sq        <= 24'sh000000;
            lin          <= 24'sh000000;
            quad         <= 36'sh000000000;
            done_out     <= 1'b0;
            result_out   <= 10'h000;
            overflow_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (start_in) begin
                        state <= S_DIFF;
                    end
                end
                S_DIFF: begin
                    // Temperature widened to 11-bit fraction minus reference
                    dt    <= $signed({1'b0, temp_in, 1'b0})
                           - $signed({1'b0, t_ref_in[10:0]});
                    state <= S_MUL;
                end
                S_MUL: begin
                    dt_sq <= dt * dt;
                    lin   <= $signed(lin_coeff_in) * dt;
                    state <= S_QUAD;
                end
                S_QUAD: begin
                    quad  <= $signed(quad_coeff_in) * dt_sq;
                    state <= S_SUM;
                end
                S_SUM: begin
                    // Drop the lowest bit of the 11-bit fraction
                    result_out   <= sum[10:1];
                    overflow_out <= sum_out_of_range;
                    done_out     <= 1'b1;
                    state        <= S_IDLE;
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

endmodule // gain_poly_alu

/* File: hw/fine_gain_temp_compensation.v */
// Fine gain temperature compensation with calibration memory and chopper
//
// Contract
// - Swap bit shifts chopping clock half period
// - Three config bits pick coarse stage gains
// - Fine gain driven by 10-bit unsigned code
// - Fraction: constant, linear times dt, quadratic dt squared
// - Reference is 12 bits, low 11 fractional
// - Constant coefficient uses low ten bits only
// - Linear coefficient is signed two's complement
// - Quadratic coefficient is signed two's complement
// - Compute at 12 bits, truncate to ten
// - Out-of-range fraction flags overflow, fault band
// - Overflow fault holds until full reset
// - Each location four data, odd parity
`timescale 1ns/100ps
`include "fine_gain_defines.vh"

// Datapath overview
// Calibration words: four data bits, odd parity on top
// Three-word values gathered low nibble first
// Temperature code scaled by a one-bit left shift
// Reference and temperature meet as 2^-11 fractions
// Difference of two 11-bit fractions fits twelve bits
// Constant coefficient doubled into the same scale
// Linear and quadratic coefficients step by 2^-10
// Linear product shifted down by ten places
// Quadratic product shifted down by twenty-one places
// Arithmetic shifts round toward minus infinity
// A sum below zero or at one counts as overflow
// Code is the sum with its lowest bit dropped
// Products sized so no term can wrap
//
// Conversion timing, counted from the taking edge
// Edge 1: coefficients and parity sampled, start raised
// Edge 2: ALU leaves idle
// Edge 3: temperature difference formed
// Edge 4: square and linear products formed
// Edge 5: quadratic product formed
// Edge 6: sum checked and truncated in the ALU
// Edge 7: code, update pulse or overflow registered
// A newer conversion replaces one still waiting
// Conversions on consecutive cycles coalesce into the later one
//
// Fault handling
// Overflow latches and freezes the last good code
// Parity failure latches at the launch of a calculation
// Calculation still runs after a parity failure
// Either fault raises the fault band request
// Only a full reset clears a latched fault
//
// Configuration
// Location 7 bit 0: input swap
// Bits 1 to 3: first, second, third stage high gain
// Bad parity in location 7 keeps the previous setting
// During reset all stages sit at low gain
//
// Chopper
// Free-running clock, half period of CHOP_HALF cycles
// Swapped inputs invert the clock, a half-period shift
// Swap loaded after reset reaches the clock at once
// Changing the swap bit mid-half while running splits that half into two short ones
//
// Calibration memory
// Contents survive reset, nonvolatile by intent
// Read-back registered, one cycle behind the address
// Writes are not parity checked; checks run at launch
// Coefficient writes reach the ALU at the next launch
// Reference top bit and two top constant bits ignored

module fine_gain_temp_compensation #(
    parameter CHOP_HALF = `CHOP_HALF_CYCLES  // Chopper half period in cycles
) (
    input  wire       clock_in,          // 25 MHz system clock
    input  wire       sys_rst_in,        // Synchronous reset, active high
    input  wire       cal_wr_in,         // Calibration word write strobe
    input  wire [5:0] cal_addr_in,       // Calibration location
    input  wire [4:0] cal_wdata_in,      // Four data bits plus parity
    output reg  [4:0] cal_rdata_out,     // Word read at cal_addr_in
    input  wire       temp_valid_in,     // New temperature conversion pulse
    input  wire [9:0] temp_code_in,      // Temperature conversion result
    output reg  [9:0] fine_gain_code_out,// Fine gain DAC code
    output reg        code_update_out,   // New code presented pulse
    output reg        input_swap_bit_out,// Inputs swapped
    output reg        chop_clk_out,      // Chopping clock
    output reg        stage1_gain_sel_out,// First stage high gain
    output reg        stage2_gain_sel_out,// Second stage high gain
    output reg        stage3_gain_sel_out,// Third stage high gain
    output reg        overflow_out,      // Arithmetic overflow latched
    output reg        parity_error_out,  // Calibration parity error latched
    output wire       fault_band_out     // Force output into fault band
);

    // Odd parity: five bits together hold an odd count of ones
    function parity_ok;
        input [4:0] word;
        begin
            parity_ok = ^word;
        end
    endfunction

    // Calibration memory, nonvolatile contents, not reset
    reg [4:0] cal_mem [0:`CAL_DEPTH-1];

    // Gather three nibbles, low nibble at the base location
    function [11:0] value12;
        input [4:0] lo;
        input [4:0] mid;
        input [4:0] hi;
        begin
            value12 = {hi[3:0], mid[3:0], lo[3:0]};
        end
    endfunction

    // Parity of a three-location value
    function parity3_ok;
        input [4:0] lo;
        input [4:0] mid;
        input [4:0] hi;
        begin
            parity3_ok = parity_ok(lo) & parity_ok(mid) & parity_ok(hi);
        end
    endfunction

    // Coefficient snapshots, held while the ALU runs
    reg  [11:0] t_ref;          // Room temperature reference
    reg  [11:0] const_coeff;    // Constant coefficient
    reg  [11:0] lin_coeff;      // Linear coefficient
    reg  [11:0] quad_coeff;     // Quadratic coefficient
    reg  [9:0]  temp_latched;   // Temperature being processed
    reg         pending;        // Conversion waiting for the ALU
    reg         alu_start;      // ALU start pulse
    reg  [3:0]  chop_cnt;       // Chopper half period counter
    reg         chop_phase;     // Unswapped chopping phase
    reg         next_swap;      // Swap bit taken at this edge

    wire        alu_busy;       // ALU running
    wire        alu_done;       // ALU result ready
    wire [9:0]  alu_result;     // ALU truncated code
    wire        alu_overflow;   // ALU range violation

    // Words that feed the polynomial and the configuration
    wire [4:0] w0  = cal_mem[`LOC_ROOM_TEMP];
    wire [4:0] w1  = cal_mem[`LOC_ROOM_TEMP + 6'h01];
    wire [4:0] w2  = cal_mem[`LOC_ROOM_TEMP + 6'h02];
    wire [4:0] w4  = cal_mem[`LOC_GAIN_QUAD];
    wire [4:0] w5  = cal_mem[`LOC_GAIN_QUAD + 6'h01];
    wire [4:0] w6  = cal_mem[`LOC_GAIN_QUAD + 6'h02];
    wire [4:0] w7  = cal_mem[`LOC_CONFIG];
    wire [4:0] w8  = cal_mem[`LOC_GAIN_LIN];
    wire [4:0] w9  = cal_mem[`LOC_GAIN_LIN + 6'h01];
    wire [4:0] w10 = cal_mem[`LOC_GAIN_LIN + 6'h02];
    wire [4:0] w12 = cal_mem[`LOC_GAIN_CONST];
    wire [4:0] w13 = cal_mem[`LOC_GAIN_CONST + 6'h01];
    wire [4:0] w14 = cal_mem[`LOC_GAIN_CONST + 6'h02];

    // All used locations pass the parity check
    wire coeff_parity_ok = parity3_ok(w0, w1, w2) & parity3_ok(w4, w5, w6)
                         & parity3_ok(w8, w9, w10) & parity3_ok(w12, w13, w14)
                         & parity_ok(w7);

    // Overflow and parity faults drive the fault band
    assign fault_band_out = overflow_out | parity_error_out;

    // Swap value taken at this edge; shared with the chopper so that
    // the clock flips together with a swap loaded after reset
    always @* begin
        if (parity_ok(w7)) begin
            next_swap = w7[`CFG_INPUT_SWAP];
        end else begin
            next_swap = input_swap_bit_out;
        end
    end

    // Calibration memory write, one word per strobe
    always @(posedge clock_in) begin
        if (cal_wr_in) begin
            cal_mem[cal_addr_in] <= cal_wdata_in;
        end
    end

    // Registered read-back of one location
    always @(posedge clock_in) begin
        if (sys_rst_in) begin
            cal_rdata_out <= 5'h00;
        end else begin
            cal_rdata_out <= cal_mem[cal_addr_in];
        end
    end

    // Configuration bits from location 7, kept only when parity holds
    always @(posedge clock_in) begin
        if (sys_rst_in) begin
            input_swap_bit_out  <= 1'b0;
            stage1_gain_sel_out <= 1'b0;
            stage2_gain_sel_out <= 1'b0;
            stage3_gain_sel_out <= 1'b0;
        end else if (parity_ok(w7)) begin
            input_swap_bit_out  <= w7[`CFG_INPUT_SWAP];
            stage1_gain_sel_out <= w7[`CFG_STAGE1_GAIN];
            stage2_gain_sel_out <= w7[`CFG_STAGE2_GAIN];
            stage3_gain_sel_out <= w7[`CFG_STAGE3_GAIN];
        end
    end

    // Chopper: free phase, inverted for swapped inputs
    // Counter wraps at CHOP_HALF, phase flips on the wrap
    always @(posedge clock_in) begin
        if (sys_rst_in) begin
            chop_cnt     <= 4'h0;
            chop_phase   <= 1'b0;
            chop_clk_out <= 1'b0;
        end else begin
            if (chop_cnt == CHOP_HALF[3:0] - 4'h1) begin
                chop_cnt   <= 4'h0;
                chop_phase <= ~chop_phase;
            end else begin
                chop_cnt <= chop_cnt + 4'h1;
            end
            // Half-period shift equals inversion of the phase
            chop_clk_out <= chop_phase ^ next_swap;
        end
    end

    // Capture a conversion and launch the ALU when free
    // Snapshot keeps coefficients still while the ALU runs
    always @(posedge clock_in) begin
        if (sys_rst_in) begin
            pending      <= 1'b0;
            alu_start    <= 1'b0;
            temp_latched <= 10'h000;
            t_ref        <= 12'h000;
            const_coeff  <= 12'h000;
            lin_coeff    <= 12'h000;
            quad_coeff   <= 12'h000;
        end else begin
            alu_start <= 1'b0;
            if (temp_valid_in) begin
                // Latest conversion replaces any waiting one
                temp_latched <= temp_code_in;
                pending      <= 1'b1;
            end else if (pending && !alu_busy && !alu_start) begin
                pending     <= 1'b0;
                alu_start   <= 1'b1;
                t_ref       <= value12(w0, w1, w2);
                const_coeff <= value12(w12, w13, w14);
                lin_coeff   <= value12(w8, w9, w10);
                quad_coeff  <= value12(w4, w5, w6);
            end
        end
    end

    // Parity error latches at a launch, cleared only by reset
    always @(posedge clock_in) begin
        if (sys_rst_in) begin
            parity_error_out <= 1'b0;
        end else if (pending && !temp_valid_in && !alu_busy && !alu_start
                     && !coeff_parity_ok) begin
            parity_error_out <= 1'b1;
        end
    end

    // Result update; code frozen once overflow is latched
    // Overflow wins over an update from the same result
    always @(posedge clock_in) begin
        if (sys_rst_in) begin
            fine_gain_code_out <= 10'h000;
            code_update_out    <= 1'b0;
            overflow_out       <= 1'b0;
        end else begin
            code_update_out <= 1'b0;
            if (alu_done) begin
                if (alu_overflow) begin
                    overflow_out <= 1'b1;
                end else if (!overflow_out) begin
                    // Previous code stays until this point
                    fine_gain_code_out <= alu_result;
                    code_update_out    <= 1'b1;
                end
            end
        end
    end

    // Polynomial evaluation
    gain_poly_alu u_alu (
        .clock_in     (clock_in),
        .sys_rst_in   (sys_rst_in),
        .start_in     (alu_start),
        .temp_in      (temp_latched),
        .t_ref_in     (t_ref),
        .const_coeff_in (const_coeff),
        .lin_coeff_in   (lin_coeff),
        .quad_coeff_in  (quad_coeff),
        .busy_out     (alu_busy),
        .done_out     (alu_done),
        .result_out   (alu_result),
        .overflow_out (alu_overflow)
    );

endmodule // fine_gain_temp_compensation

/* File: verif/fine_gain_monitor.sv */
// Port checker for the fine gain compensation block
`timescale 1ns/100ps
module fine_gain_monitor #(
    parameter CHOP_HALF = 8                 // Chopper half period
) (
    input wire       clock_in,              // System clock
    input wire       sys_rst_in,            // Synchronous reset
    input wire       cal_wr_in,             // Write strobe
    input wire [5:0] cal_addr_in,           // Location
    input wire [4:0] cal_wdata_in,          // Written word
    input wire [4:0] cal_rdata_out,         // Read-back word
    input wire       temp_valid_in,         // New conversion
    input wire [9:0] fine_gain_code_out,    // Fine gain code
    input wire       code_update_out,       // Code update pulse
    input wire       chop_clk_out,          // Chopping clock
    input wire       overflow_out,          // Overflow fault
    input wire       parity_error_out,      // Parity fault
    input wire       fault_band_out         // Fault band request
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);
    // Write followed by one cycle of held address
    sequence wr_held;
        cal_wr_in ##1 ($stable(cal_addr_in) && !cal_wr_in);
    endsequence
    readback_ok_a:
    assert property (wr_held |=> cal_rdata_out == $past(cal_wdata_in, 2))
        else $error("read-back word differs from written word");
    latency_bound_a:
    assert property (temp_valid_in && !overflow_out |-> ##[7:30] (code_update_out || overflow_out))
        else $error("no code update after conversion");
    update_pulse_a:
    assert property (code_update_out |=> !code_update_out)
        else $error("update pulse longer than one cycle");
    code_hold_a:
    assert property ($changed(fine_gain_code_out) |-> code_update_out)
        else $error("code changed without update pulse");
    sticky_ovf_a:
    assert property (overflow_out |=> overflow_out)
        else $error("overflow fault dropped before reset");
    no_update_ovf_a:
    assert property ($past(overflow_out) |-> !code_update_out)
        else $error("code updated after overflow");
    fault_or_a:
    assert property (fault_band_out == (overflow_out || parity_error_out))
        else $error("fault band does not follow faults");
    sticky_parity_a:
    assert property (parity_error_out |=> parity_error_out)
        else $error("parity fault dropped before reset");
    chop_half_a:
    assert property ($changed(chop_clk_out) && !$past(sys_rst_in, 2) |=> $stable(chop_clk_out)[*7])
        else $error("chopping half period wrong");
endmodule // fine_gain_monitor

bind fine_gain_temp_compensation fine_gain_monitor #(.CHOP_HALF(CHOP_HALF)) i_fine_gain_monitor (
    .clock_in, .sys_rst_in, .cal_wr_in, .cal_addr_in, .cal_wdata_in, .cal_rdata_out,
    .temp_valid_in, .fine_gain_code_out, .code_update_out, .chop_clk_out,
    .overflow_out, .parity_error_out, .fault_band_out);

/* File: verif/cal_programmer_model.sv */
// Calibration programmer model writing odd-parity words
`timescale 1ns/100ps
module cal_programmer_model (
    input  wire       clock_in,       // System clock
    output reg        cal_wr_out,     // Write strobe
    output reg  [5:0] cal_addr_out,   // Location
    output reg  [4:0] cal_wdata_out   // Data plus parity
);
    // Idle bus at start
    initial begin
        cal_wr_out = 1'b0;
        cal_addr_out = 6'h00;
        cal_wdata_out = 5'h00;
    end
    // One word; bad spoils the parity on purpose
    task put_word(input [5:0] a, input [3:0] d, input bad);
        begin
            @(negedge clock_in);
            cal_wr_out = 1'b1;
            cal_addr_out = a;
            cal_wdata_out = {~^d ^ bad, d};
            @(negedge clock_in);
            cal_wr_out = 1'b0;
            cal_wdata_out = ~cal_wdata_out; // Data line inverted after the strobe
        end
    endtask
    // 12-bit value, low nibble at base
    task put_value(input [5:0] b, input [11:0] v);
        begin
            put_word(b, v[3:0], 1'b0);
            put_word(b + 6'h01, v[7:4], 1'b0);
            put_word(b + 6'h02, v[11:8], 1'b0);
        end
    endtask
endmodule // cal_programmer_model

/* File: verif/tb.sv */
// Self-checking bench for the fine gain compensation block
`timescale 1ns/100ps
module tb;
    reg         clock_in = 1'b0;      // System clock
    reg         sys_rst_in = 1'b1;    // Reset
    reg         temp_valid_in = 1'b0; // Conversion pulse
    reg  [9:0]  temp_code_in = 10'h000;
    wire        cal_wr_in, code_update_out, input_swap_bit_out, chop_clk_out;
    wire        stage1_gain_sel_out, stage2_gain_sel_out, stage3_gain_sel_out;
    wire        overflow_out, parity_error_out, fault_band_out;
    wire [5:0]  cal_addr_in;
    wire [4:0]  cal_wdata_in, cal_rdata_out;
    wire [9:0]  fine_gain_code_out;
    reg  [11:0] rf, coef_const, coef_lin, coef_quad; // Stored coefficients
    reg  [9:0]  prev;                 // Code before overflow
    reg         ph0, upd;             // Chop phase, update seen
    integer     fail_count = 0, compares = 0, k;
    reg  [9:0]  temps [0:3];          // Conversion table
    always #20 clock_in = ~clock_in;
    cal_programmer_model i_cal_programmer_model (.clock_in, .cal_wr_out(cal_wr_in),
        .cal_addr_out(cal_addr_in), .cal_wdata_out(cal_wdata_in));
    fine_gain_temp_compensation i_fine_gain_temp_compensation (.clock_in, .sys_rst_in,
        .cal_wr_in, .cal_addr_in, .cal_wdata_in, .cal_rdata_out, .temp_valid_in,
        .temp_code_in, .fine_gain_code_out, .code_update_out, .input_swap_bit_out,
        .chop_clk_out, .stage1_gain_sel_out, .stage2_gain_sel_out, .stage3_gain_sel_out,
        .overflow_out, .parity_error_out, .fault_band_out);
    // Compare and count
    task chk(input string nm, input [11:0] seen, input [11:0] exp);
        begin
            compares = compares + 1;
            if (seen !== exp) begin
                fail_count = fail_count + 1;
                $display("ERROR %0s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    // Expected {overflow, code} of the polynomial
    function [10:0] calc(input [9:0] t);
        longint dt, s, a, b, c;
        begin
            dt = {t, 1'b0};
            dt = dt - rf[10:0];
            a = coef_const[9:0];
            b = $signed(coef_lin);
            c = $signed(coef_quad);
            s = 2 * a + ((b * dt) >>> 10) + ((c * dt * dt) >>> 21);
            calc = {(s < 0 || s >= 2048), s[10:1]};
        end
    endfunction
    // Reset for 16 cycles, then settle
    task rst;
        begin
            sys_rst_in = 1'b1;
            repeat (16) @(negedge clock_in);
            sys_rst_in = 1'b0;
            repeat (5) @(negedge clock_in);
        end
    endtask
    // One conversion, wait for the update pulse
    task conv(input [9:0] t);
        begin
            temp_code_in = t;
            temp_valid_in = 1'b1;
            @(negedge clock_in);
            temp_valid_in = 1'b0;
            upd = 1'b0;
            for (k = 0; k < 20 && !upd; k = k + 1) begin
                @(negedge clock_in);
                upd = (code_update_out === 1'b1);
            end
        end
    endtask
    task give_verdict;
        begin
            $display("compares %0d fail_count %0d", compares, fail_count);
            if (fail_count == 0 && compares > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    // Watchdog
    initial begin
        #400000;
        fail_count = fail_count + 1;
        give_verdict;
    end
    // Main sequence
    initial begin
        temps[0] = 10'h200; temps[1] = 10'h3ff; temps[2] = 10'h000; temps[3] = 10'h280;
        rst;
        chk("reset code", fine_gain_code_out, 12'h000);
        // Reference: two 0x200 readings summed, 11-bit mean
        rf = {2'b00, temps[0]} + {2'b00, temps[0]};
        coef_const = 12'h100;
        coef_lin = 12'hf00;
        coef_quad = 12'h100;
        i_cal_programmer_model.put_value(6'h00, rf);
        i_cal_programmer_model.put_value(6'h04, coef_quad);
        i_cal_programmer_model.put_value(6'h08, coef_lin);
        i_cal_programmer_model.put_value(6'h0c, coef_const);
        @(negedge clock_in);
        chk("read-back", cal_rdata_out, {7'h00, ~^coef_const[11:8], coef_const[11:8]});
        i_cal_programmer_model.put_word(6'h07, 4'he, 1'b0);
        rst;
        chk("config", {stage3_gain_sel_out, stage2_gain_sel_out, stage1_gain_sel_out,
            input_swap_bit_out}, 12'h00e);
        ph0 = chop_clk_out;
        for (int i = 0; i < 4; i++) begin
            conv(temps[i]);
            chk("update", upd, 12'h001);
            chk("code", fine_gain_code_out, calc(temps[i]) & 11'h3ff);
            chk("overflow", overflow_out, 12'h000);
        end
        // Swap bit changes only while the block is held in reset
        sys_rst_in = 1'b1;
        i_cal_programmer_model.put_word(6'h07, 4'h1, 1'b0);
        rst;
        chk("swap config", {stage3_gain_sel_out, stage2_gain_sel_out, stage1_gain_sel_out,
            input_swap_bit_out}, 12'h001);
        chk("chop phase", chop_clk_out, {11'h000, ~ph0});
        i_cal_programmer_model.put_word(6'h05, coef_quad[7:4], 1'b1);
        conv(10'h200);
        chk("parity", parity_error_out, 12'h001);
        chk("fault", fault_band_out, 12'h001);
        i_cal_programmer_model.put_value(6'h04, coef_quad);
        rst;
        chk("parity cleared", parity_error_out, 12'h000);
        coef_lin = 12'h7ff;
        i_cal_programmer_model.put_value(6'h08, coef_lin);
        prev = fine_gain_code_out;
        conv(10'h3ff);
        chk("overflow", overflow_out, calc(10'h3ff) >> 10);
        chk("fault", fault_band_out, 12'h001);
        chk("held code", fine_gain_code_out, prev);
        conv(10'h200);
        chk("refused", upd, 12'h000);
        rst;
        chk("overflow cleared", overflow_out, 12'h000);
        conv(10'h280);
        chk("code", fine_gain_code_out, calc(10'h280) & 11'h3ff);
        give_verdict;
    end
endmodule // tb
